// >>> hdl/ppmi_top.sv
//******************************************************************
// Purpose : Pattern match interrupt on an 8-bit input port
// Assumes : Classic Wishbone slave, 20 MHz core clock, sync reset
// Notes   : Port pins are synchronised before comparison
//
// Contract
// R1 - Compare the synchronised port against the programmed match pattern.
// R2 - Only pins selected in the pin select mask take part.
// R3 - Set the match flag when the condition holds while active.
// R4 - Raise the interrupt while the flag is set and enabled.
// R5 - Polarity bit chooses equal or not-equal as the match.
// R6 - Pattern all ones, not-equal: any selected pin low matches.
// R7 - Match must persist more than six core clocks before setting.
// R8 - Enabled match interrupt wakes the processor from idle or power-down.
// R9 - Flag stays set until software writes zero; reset clears it.
//******************************************************************
`timescale 1ns/1ps
module ppmi_top
    import ppmi_pkg::*;
(
    input  wire logic                   CLK_I,
    input  wire logic                   SYS_RST_I,
    input  wire logic [PPMI_ADR_W-1:0]  ADR_I,
    input  wire logic [PPMI_DATA_W-1:0] DAT_I,
    input  wire logic [3:0]             SEL_I,
    input  wire logic                   WE_I,
    input  wire logic                   CYC_I,
    input  wire logic                   STB_I,
    output logic                        ACK_O,
    output logic      [PPMI_DATA_W-1:0] DAT_O,
    input  wire logic [PPMI_PORT_W-1:0] PORT_I,
    input  wire logic                   IDLE_I,
    input  wire logic                   PWRDN_I,
    output logic                        IRQ_O,
    output logic                        WAKE_O
);

    //**************************************************************
    // Declarations
    //**************************************************************
    logic [PPMI_PORT_W-1:0] port_s;
    logic                   qual;
    logic                   match_c;
    logic [PPMI_PORT_W-1:0] masked_port;
    logic [PPMI_PORT_W-1:0] masked_patn;

    logic                   ack_r;
    logic                   ack_nxt;
    logic [PPMI_DATA_W-1:0] dat_r;
    logic [PPMI_DATA_W-1:0] dat_nxt;
    logic                   wr_c;
    logic                   lane0_c;

    logic [PPMI_PORT_W-1:0] mask_r;
    logic [PPMI_PORT_W-1:0] mask_nxt;
    logic [PPMI_PORT_W-1:0] patn_r;
    logic [PPMI_PORT_W-1:0] patn_nxt;
    logic                   pol_r;
    logic                   pol_nxt;
    logic                   act_r;
    logic                   act_nxt;

    logic [PPMI_EV_W-1:0]   sts_r;
    logic [PPMI_EV_W-1:0]   sts_nxt;
    logic [PPMI_EV_W-1:0]   ien_r;
    logic [PPMI_EV_W-1:0]   ien_nxt;
    logic [PPMI_EV_W-1:0]   ev_c;
    logic [PPMI_EV_W-1:0]   clr_c;
    logic                   sleep_c;
    logic                   irq_r;
    logic                   irq_nxt;
    logic                   wake_r;
    logic                   wake_nxt;

    //**************************************************************
    // Pin synchroniser and persistence filter
    //**************************************************************
    ppmi_sync u_sync (
        .clk_i (CLK_I),
        .rst_i (SYS_RST_I),
        .pin_i (PORT_I),
        .pin_o (port_s)
    );

    ppmi_hold_filter u_hold (
        .clk_i   (CLK_I),
        .rst_i   (SYS_RST_I),
        .match_i (match_c),
        .qual_o  (qual)
    );

    //**************************************************************
    // Comparator
    //**************************************************************
    // An empty mask matches nothing, even in equal mode
    always_comb begin
        masked_port = port_s & mask_r;                        // see R2
        masked_patn = patn_r & mask_r;                        // see R2
        match_c     = 1'b0;
        if (act_r && (mask_r != PPMI_NONE)) begin
            if (pol_r) begin
                match_c = (masked_port != masked_patn);       // see R5 see R6
            end else begin
                match_c = (masked_port == masked_patn);       // see R1
            end
        end
    end

    //**************************************************************
    // Wishbone slave
    //**************************************************************
    // Write lands on the edge where the master samples ack
    assign wr_c    = CYC_I && STB_I && WE_I && ack_r;
    assign lane0_c = SEL_I[0];

    always_comb begin
        ack_nxt = CYC_I && STB_I && !ack_r;
        dat_nxt = dat_r;
        if (CYC_I && STB_I && !ack_r) begin
            dat_nxt = '0;
            if (ADR_I == PPMI_ADR_CTRL) begin
                dat_nxt[PPMI_CTRL_FLAG] = sts_r[PPMI_STS_MATCH];
                dat_nxt[PPMI_CTRL_POL]  = pol_r;
                dat_nxt[PPMI_CTRL_ACT]  = act_r;
            end else if (ADR_I == PPMI_ADR_MASK) begin
                dat_nxt[PPMI_PORT_W-1:0] = mask_r;
            end else if (ADR_I == PPMI_ADR_PATN) begin
                dat_nxt[PPMI_PORT_W-1:0] = patn_r;
            end else if (ADR_I == PPMI_ADR_PORT) begin
                dat_nxt[PPMI_PORT_W-1:0] = port_s;
            end else if (ADR_I == PPMI_ADR_STS) begin
                dat_nxt[PPMI_EV_W-1:0] = sts_r;
            end else if (ADR_I == PPMI_ADR_IEN) begin
                dat_nxt[PPMI_EV_W-1:0] = ien_r;
            end
        end
    end

    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            ack_r <= 1'b0;
            dat_r <= '0;
        end else begin
            ack_r <= ack_nxt;
            dat_r <= dat_nxt;
        end
    end

    //**************************************************************
    // Configuration registers
    //**************************************************************
    always_comb begin
        mask_nxt = mask_r;
        patn_nxt = patn_r;
        pol_nxt  = pol_r;
        act_nxt  = act_r;
        ien_nxt  = ien_r;
        if (wr_c && lane0_c) begin
            if (ADR_I == PPMI_ADR_CTRL) begin
                pol_nxt = DAT_I[PPMI_CTRL_POL];
                act_nxt = DAT_I[PPMI_CTRL_ACT];
            end else if (ADR_I == PPMI_ADR_MASK) begin
                mask_nxt = DAT_I[PPMI_PORT_W-1:0];
            end else if (ADR_I == PPMI_ADR_PATN) begin
                patn_nxt = DAT_I[PPMI_PORT_W-1:0];
            end else if (ADR_I == PPMI_ADR_IEN) begin
                ien_nxt = DAT_I[PPMI_EV_W-1:0];
            end
        end
    end

    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            mask_r <= PPMI_MASK_RST;
            patn_r <= PPMI_PATN_RST;
            pol_r  <= PPMI_POL_RST;
            act_r  <= PPMI_ACT_RST;
            ien_r  <= PPMI_EV_RST;
        end else begin
            mask_r <= mask_nxt;
            patn_r <= patn_nxt;
            pol_r  <= pol_nxt;
            act_r  <= act_nxt;
            ien_r  <= ien_nxt;
        end
    end

    //**************************************************************
    // Flags, interrupt and wake
    //**************************************************************
    // Qualified match is a level: a clear during a held match
    // loses to the set, so the flag stays set
    always_comb begin
        sleep_c = IDLE_I || PWRDN_I;
        ev_c    = '0;
        ev_c[PPMI_STS_MATCH] = qual;                          // see R3
        ev_c[PPMI_STS_WAKE]  = qual && sleep_c;               // see R8
        clr_c   = '0;
        if (wr_c && lane0_c) begin
            if (ADR_I == PPMI_ADR_ICLR) begin
                clr_c = DAT_I[PPMI_EV_W-1:0];
            end else if (ADR_I == PPMI_ADR_CTRL) begin
                clr_c[PPMI_STS_MATCH] = !DAT_I[PPMI_CTRL_FLAG];  // see R9
            end
        end
        sts_nxt  = (sts_r & ~clr_c) | ev_c;                   // see R9
        irq_nxt  = |(sts_nxt & ien_nxt);                      // see R4
        wake_nxt = sleep_c && irq_nxt;                        // see R8
    end

    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            sts_r  <= PPMI_EV_RST;                            // see R9
            irq_r  <= 1'b0;
            wake_r <= 1'b0;
        end else begin
            sts_r  <= sts_nxt;
            irq_r  <= irq_nxt;
            wake_r <= wake_nxt;
        end
    end

    assign ACK_O  = ack_r;
    assign DAT_O  = dat_r;
    assign IRQ_O  = irq_r;
    assign WAKE_O = wake_r;

    //**************************************************************
    // Assertions
    //**************************************************************
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (SYS_RST_I);

    a_cmp_equal: assert property (  // see R1
        (act_r && !pol_r && mask_r != PPMI_NONE && masked_port == masked_patn)
        |-> match_c)
        else $error("equal pattern not matched");

    a_mask_gate: assert property (  // see R2
        (mask_r == PPMI_NONE) |-> !match_c)
        else $error("match with empty mask");

    a_cmp_differ: assert property (  // see R5
        (act_r && pol_r && masked_port == masked_patn) |-> !match_c)
        else $error("not-equal mode matched an equal port");

    a_any_low: assert property (  // see R6
        (act_r && pol_r && patn_r == PPMI_ALL_ONES && |(mask_r & ~port_s))
        |-> match_c)
        else $error("selected low pin did not match");

    a_hold_time: assert property (  // see R7
        $rose(qual) |-> $past(match_c, 1) && $past(match_c, 2)
        && $past(match_c, 3) && $past(match_c, 4) && $past(match_c, 5)
        && $past(match_c, 6) && $past(match_c, 7))
        else $error("flag qualified before hold time");

    a_hold_sets: assert property (  // see R7
        match_c [*7] |=> qual)
        else $error("persistent match not qualified");

    a_flag_sets: assert property (  // see R3
        qual |=> sts_r[PPMI_STS_MATCH])
        else $error("flag not set by qualified match");

    a_irq_level: assert property (  // see R4
        (sts_r[PPMI_STS_MATCH] && ien_r[PPMI_STS_MATCH]) |-> IRQ_O)
        else $error("interrupt low with enabled flag");

    a_wake_sleep: assert property (  // see R8
        (qual && sleep_c && ien_r[PPMI_STS_MATCH]) |=> WAKE_O)
        else $error("no wake on match in sleep");

    a_flag_sticky: assert property (  // see R9
        (sts_r[PPMI_STS_MATCH] && !clr_c[PPMI_STS_MATCH])
        |=> sts_r[PPMI_STS_MATCH])
        else $error("flag dropped without software clear");

    a_ack_pulse: assert property (
        ACK_O |=> !ACK_O)
        else $error("ack held for two cycles");

    c_flag_set:  cover property ($rose(sts_r[PPMI_STS_MATCH]));
    c_wake:      cover property ($rose(WAKE_O));
    c_irq:       cover property ($rose(IRQ_O));
    c_sw_clear:  cover property ($fell(sts_r[PPMI_STS_MATCH]));

endmodule

// >>> hdl/ppmi_pkg.sv
//******************************************************************
// Purpose : Shared constants of the port pattern match interrupt
// Assumes : 8-bit port, 32-bit classic Wishbone, one core clock
// Notes   : Registers are one aligned word each, data in bits 7:0
//******************************************************************
package ppmi_pkg;

    //**************************************************************
    // Widths
    //**************************************************************
    localparam int PPMI_PORT_W = 8;
    localparam int PPMI_DATA_W = 32;
    localparam int PPMI_ADR_W  = 8;
    localparam int PPMI_EV_W   = 2;
    localparam int PPMI_CNT_W  = 3;

    //**************************************************************
    // Register byte addresses
    //**************************************************************
    localparam logic [7:0] PPMI_ADR_CTRL = 8'h00;
    localparam logic [7:0] PPMI_ADR_MASK = 8'h04;
    localparam logic [7:0] PPMI_ADR_PATN = 8'h08;
    localparam logic [7:0] PPMI_ADR_PORT = 8'h0c;
    localparam logic [7:0] PPMI_ADR_STS  = 8'h10;
    localparam logic [7:0] PPMI_ADR_IEN  = 8'h14;
    localparam logic [7:0] PPMI_ADR_ICLR = 8'h18;

    //**************************************************************
    // Field positions
    //**************************************************************
    localparam int PPMI_CTRL_FLAG = 0;
    localparam int PPMI_CTRL_POL  = 1;
    localparam int PPMI_CTRL_ACT  = 2;
    localparam int PPMI_STS_MATCH = 0;
    localparam int PPMI_STS_WAKE  = 1;

    //**************************************************************
    // Reset values
    //**************************************************************
    localparam logic [7:0] PPMI_MASK_RST = 8'h00;
    localparam logic [7:0] PPMI_PATN_RST = 8'hff;
    localparam logic       PPMI_POL_RST  = 1'b0;
    localparam logic       PPMI_ACT_RST  = 1'b0;
    localparam logic [1:0] PPMI_EV_RST   = 2'h0;
    localparam logic [7:0] PPMI_ALL_ONES = 8'hff;
    localparam logic [7:0] PPMI_NONE     = 8'h00;

    //**************************************************************
    // Timing: pattern must persist more than this many core clocks
    //**************************************************************
    localparam int PPMI_HOLD_CYCLES = 6;
    localparam logic [PPMI_CNT_W-1:0] PPMI_HOLD_LIMIT = PPMI_CNT_W'(PPMI_HOLD_CYCLES + 1);
    localparam logic [PPMI_CNT_W-1:0] PPMI_CNT_ONE    = 3'h1;
    localparam logic [PPMI_CNT_W-1:0] PPMI_CNT_ZERO   = 3'h0;

endpackage

// >>> hdl/ppmi_sync.sv
//******************************************************************
// Purpose : Two-stage synchroniser for the port pins
// Assumes : Pins are asynchronous to the core clock
// Notes   : First stage feeds only the second stage
//******************************************************************
`timescale 1ns/1ps
module ppmi_sync
    import ppmi_pkg::*;
(
    input  wire logic                   clk_i,
    input  wire logic                   rst_i,
    input  wire logic [PPMI_PORT_W-1:0] pin_i,
    output logic      [PPMI_PORT_W-1:0] pin_o
);

    logic [PPMI_PORT_W-1:0] meta_r;
    logic [PPMI_PORT_W-1:0] meta_nxt;
    logic [PPMI_PORT_W-1:0] sync_r;
    logic [PPMI_PORT_W-1:0] sync_nxt;

    genvar b;
    generate
        for (b = 0; b < PPMI_PORT_W; b++) begin : g_bit
            always_comb begin
                meta_nxt[b] = pin_i[b];
                sync_nxt[b] = meta_r[b];
            end
            // Reset to ones: idle pins of a keypad read high
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    meta_r[b] <= 1'b1;
                    sync_r[b] <= 1'b1;
                end else begin
                    meta_r[b] <= meta_nxt[b];
                    sync_r[b] <= sync_nxt[b];
                end
            end
        end
    endgenerate

    assign pin_o = sync_r;

endmodule

// >>> hdl/ppmi_hold_filter.sv
//******************************************************************
// Purpose : Qualifies a match that persists past the hold time
// Assumes : match_i comes from logic on the same clock
// Notes   : Counter saturates, so a long match stays qualified
//******************************************************************
`timescale 1ns/1ps
module ppmi_hold_filter
    import ppmi_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic match_i,
    output logic      qual_o
);

    logic [PPMI_CNT_W-1:0] cnt_r;
    logic [PPMI_CNT_W-1:0] cnt_nxt;
    logic                  qual_r;
    logic                  qual_nxt;

    always_comb begin
        cnt_nxt = cnt_r;
        if (!match_i) begin
            cnt_nxt = PPMI_CNT_ZERO;
        end else if (cnt_r < PPMI_HOLD_LIMIT) begin
            cnt_nxt = cnt_r + PPMI_CNT_ONE;
        end
        qual_nxt = (cnt_nxt == PPMI_HOLD_LIMIT);  // see R7
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_r  <= PPMI_CNT_ZERO;
            qual_r <= 1'b0;
        end else begin
            cnt_r  <= cnt_nxt;
            qual_r <= qual_nxt;
        end
    end

    assign qual_o = qual_r;

endmodule

// >>> tb/ppmi_keypad_model.sv
// Purpose : Keypad at the port pins, presses a pattern for a set time
// Assumes : Pins are pulled up, a closed key pulls its pin low
// Notes   : Changes pins only just after a rising core clock edge
`timescale 1ns/1ps
module ppmi_keypad_model
    import ppmi_pkg::*;
(
    input  wire logic                   clk_i,
    input  wire logic                   go_i,
    input  wire logic [PPMI_PORT_W-1:0] pat_i,
    input  wire logic [7:0]             len_i,
    output logic      [PPMI_PORT_W-1:0] port_o
);
    //**************************************************************
    // Press timing
    //**************************************************************
    logic [PPMI_PORT_W-1:0] port_r = PPMI_ALL_ONES;
    logic [7:0]             left_r = 8'h00;

    // Held exactly len_i cycles, then pull-ups win again
    always_ff @(posedge clk_i) begin
        if (go_i) begin
            port_r <= pat_i;
            left_r <= len_i;
        end else if (left_r > 8'h01) begin
            left_r <= left_r - 8'h01;
        end else begin
            left_r <= 8'h00;
            port_r <= PPMI_ALL_ONES;
        end
    end

    assign port_o = port_r;
endmodule

// >>> tb/tb_top.sv
// Purpose : Self-checking bench of the port pattern match interrupt
// Assumes : Classic Wishbone master, 50 ns core clock
// Notes   : Status is cleared between scenarios through the clear register
`timescale 1ns/1ps
module tb_top
    import ppmi_pkg::*;
;
    logic                   clk = 1'b0;
    logic                   rst = 1'b1;
    logic [PPMI_ADR_W-1:0]  adr = 8'h00;
    logic [PPMI_DATA_W-1:0] wdat = 32'h0;
    logic [3:0]             sel = 4'h0;
    logic                   we = 1'b0;
    logic                   cyc = 1'b0;
    logic                   stb = 1'b0;
    logic                   ack;
    logic [PPMI_DATA_W-1:0] rdat;
    logic [PPMI_PORT_W-1:0] port;
    logic                   idle = 1'b0;
    logic                   pwrdn = 1'b0;
    logic                   irq;
    logic                   wake;
    logic                   go = 1'b0;
    logic [PPMI_PORT_W-1:0] pat = 8'hff;
    logic [7:0]             len = 8'h00;
    int                     n_errors = 0;
    int                     tests_run = 0;

    initial begin
        forever #25 clk = ~clk;
    end

    ppmi_top dut_u (
        .CLK_I(clk), .SYS_RST_I(rst), .ADR_I(adr), .DAT_I(wdat), .SEL_I(sel),
        .WE_I(we), .CYC_I(cyc), .STB_I(stb), .ACK_O(ack), .DAT_O(rdat),
        .PORT_I(port), .IDLE_I(idle), .PWRDN_I(pwrdn), .IRQ_O(irq), .WAKE_O(wake)
    );

    ppmi_keypad_model key_u (
        .clk_i(clk), .go_i(go), .pat_i(pat), .len_i(len), .port_o(port)
    );

    //**************************************************************
    // Tasks
    //**************************************************************
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("FAIL %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    // Request held until the edge that samples ack high
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'hf;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        q = rdat;
        if (ack !== 1'b1) check(32'h1, 32'h0, "no ack");
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] q;
        wb(1'b1, a, {24'h0, d}, q);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e, input string msg);
        logic [31:0] q;
        wb(1'b0, a, 32'h0, q);
        check(q, {24'h0, e}, msg);
    endtask

    // Starts a press; pins show p from the edge at which it returns
    task automatic key_on(input logic [7:0] p, input logic [7:0] n);
        @(posedge clk);
        pat <= p;
        len <= n;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
    endtask

    // Latency pin to flag is 10 edges, so len plus 12 covers it
    task automatic press(input logic [7:0] p, input logic [7:0] n);
        key_on(p, n);
        repeat (int'(n) + 12) @(posedge clk);
    endtask

    task automatic test_done;
        if (n_errors == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    //**************************************************************
    // Scenarios
    //**************************************************************
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd(PPMI_ADR_CTRL, 8'h00, "ctrl reset");
        rd(PPMI_ADR_STS, 8'h00, "sts reset");
        rd(PPMI_ADR_MASK, PPMI_MASK_RST, "mask reset");
        rd(PPMI_ADR_PATN, PPMI_PATN_RST, "pattern reset");
        rd(8'h1c, 8'h00, "unmapped");
        rd(PPMI_ADR_ICLR, 8'h00, "clear reads zero");
        wr(PPMI_ADR_MASK, 8'h0f);
        wr(PPMI_ADR_IEN, 8'h01);
        wr(PPMI_ADR_CTRL, 8'h06);
        press(8'hbf, 8'd20);
        rd(PPMI_ADR_STS, 8'h00, "unselected pin");
        check({31'h0, irq}, 32'h0, "irq unselected");
        press(8'hfb, 8'd20);
        rd(PPMI_ADR_STS, 8'h01, "key low");
        rd(PPMI_ADR_CTRL, 8'h07, "ctrl flag");
        check({31'h0, irq}, 32'h1, "irq set");
        wr(PPMI_ADR_CTRL, 8'h07);
        rd(PPMI_ADR_STS, 8'h01, "write one keeps");
        wr(PPMI_ADR_CTRL, 8'h06);
        rd(PPMI_ADR_STS, 8'h00, "write zero clears");
        check({31'h0, irq}, 32'h0, "irq cleared");
        press(8'hfe, 8'd6);
        rd(PPMI_ADR_STS, 8'h00, "six cycles");
        press(8'hfe, 8'd7);
        rd(PPMI_ADR_STS, 8'h01, "seven cycles");
        wr(PPMI_ADR_ICLR, 8'h01);
        rd(PPMI_ADR_STS, 8'h00, "clear reg");
        wr(PPMI_ADR_IEN, 8'h00);
        press(8'hfe, 8'd20);
        rd(PPMI_ADR_STS, 8'h01, "flag masked");
        check({31'h0, irq}, 32'h0, "irq masked");
        wr(PPMI_ADR_IEN, 8'h01);
        rd(PPMI_ADR_IEN, 8'h01, "enable readback");
        check({31'h0, irq}, 32'h1, "irq enabled late");
        wr(PPMI_ADR_ICLR, 8'h01);
        for (int k = 0; k < 2; k++) begin
            idle <= (k == 0);
            pwrdn <= (k == 1);
            press(8'hf7, 8'd20);
            check({31'h0, wake}, 32'h1, "wake");
            rd(PPMI_ADR_STS, 8'h03, "wake status");
            wr(PPMI_ADR_ICLR, 8'h03);
            rd(PPMI_ADR_STS, 8'h00, "wake cleared");
            check({31'h0, wake}, 32'h0, "wake off");
        end
        idle <= 1'b0;
        pwrdn <= 1'b0;
        wr(PPMI_ADR_CTRL, 8'h04);
        wr(PPMI_ADR_MASK, 8'hff);
        wr(PPMI_ADR_PATN, 8'ha5);
        press(8'ha4, 8'd20);
        rd(PPMI_ADR_STS, 8'h00, "equal mode miss");
        press(8'ha5, 8'd40);
        rd(PPMI_ADR_STS, 8'h01, "equal mode hit");
        // Port register must be read while the key is still held
        key_on(8'h5a, 8'd30);
        repeat (4) @(posedge clk);
        rd(PPMI_ADR_PORT, 8'h5a, "port value");
        repeat (40) @(posedge clk);
        rd(PPMI_ADR_PORT, 8'hff, "port released");
        test_done;
    end

    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        test_done;
    end
endmodule
